// File: rtl/ulc_line_ctrl.v
/*
 * Serial port core with line format and modem output control, reached
 * over APB. Holds the line format, modem control, divisor latch, a one
 * character receive buffer and a line status word.
 * Assumes all inputs synchronous to sys_clk.
 */
// Summary of operation
// - word length code 0..3 selects 5..8 data bits
// - stop select 0 gives one stop bit; 1 gives two, or 1.5 at 5 bits
// - parity enable adds parity on transmit and checks it on receive
// - parity code 0 is odd, code 1 is even, over data plus parity
// - parity code 2 forces parity 1, code 3 forces parity 0
// - break bit holds the transmit pin low outside loopback
// - latch access bit routes offsets to the divisor latches
// - modem control bit 0 drives the terminal ready pin outside loopback
// - modem control bit 1 drives the active low request to send pin outside loopback
// - in loopback both modem control bits read back as zero
// - all format and modem control fields reset to zero
// - loopback feeds transmitter to receiver; pin marks, input ignored
// - with latch access clear, offset zero reads the receive buffer
`timescale 1ns/1ns
`default_nettype none
`include "ulc_map.vh"

module ulc_line_ctrl
(
   // clock and reset
   input wire sys_clk,
   input wire rst_n,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // serial line
   input wire serialIn,
   output reg serialOut,
   // modem outputs
   output reg terminalReadyN,
   output reg requestSendN
);

   localparam [4:0] RX_IDLE = 5'b00001;
   localparam [4:0] RX_START = 5'b00010;
   localparam [4:0] RX_DATA = 5'b00100;
   localparam [4:0] RX_PAR = 5'b01000;
   localparam [4:0] RX_STOP = 5'b10000;

   // ----------------------------------------------------------------
   // registers and field views
   // ----------------------------------------------------------------
   reg [7:0] lineFmt;
   reg terminalReadyCtl;
   reg requestSendCtl;
   reg loopbackSelect;
   reg [15:0] divisor;
   reg [15:0] divCnt;
   reg tick;
   reg txStart;
   reg [7:0] txData;
   reg [7:0] rxBuf;
   reg rxReady;
   reg parityErr;
   reg framingErr;
   reg [4:0] rxState;
   reg [3:0] rxCnt;
   reg [2:0] rxBit;
   reg [7:0] rxShift;
   reg rxPar;
   reg [31:0] readVal;
   reg hit;

   wire txBusy;
   wire txLine;
   wire [1:0] wordLengthSel = lineFmt[`ULC_LCR_LEN_LSB +: 2];
   wire parityEnable = lineFmt[`ULC_LCR_PAR];
   wire [1:0] parityTypeSel = lineFmt[`ULC_LCR_PTY_LSB +: 2];
   wire breakForce = lineFmt[`ULC_LCR_BRK];
   wire divisorLatchAccess = lineFmt[`ULC_LCR_DIV];
   wire [2:0] lastBit = {1'b0, wordLengthSel} + 3'd4;

   wire setup = psel & ~penable;
   wire done = psel & penable & pready;
   wire wrDone = done & pwrite;
   wire rdDone = done & ~pwrite;
   wire selBuf = (paddr == `ULC_ADDR_BUF);
   wire selDivHi = (paddr == `ULC_ADDR_DIVHI);
   wire selLcr = (paddr == `ULC_ADDR_LCR);
   wire selMcr = (paddr == `ULC_ADDR_MCR);
   wire selStat = (paddr == `ULC_ADDR_STAT);

   // break reaches the receiver too, so loopback can observe it
   wire internalTx = breakForce ? 1'b0 : txLine;
   wire rxLine = loopbackSelect ? internalTx : serialIn;

   function parityOf;
      input [7:0] d;
      input [1:0] wl;
      input [1:0] sel;
      reg [7:0] m;
      begin
         m = d & (8'hff >> (2'd3 - wl));
         case (sel)
            2'h0: parityOf = ~^m;
            2'h1: parityOf = ^m;
            2'h2: parityOf = 1'b1;
            default: parityOf = 1'b0;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // transmitter
   // ----------------------------------------------------------------
   ulc_serial_tx u_tx
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tick(tick),
      .start(txStart),
      .data(txData),
      .format(lineFmt),
      .busy(txBusy),
      .txLine(txLine)
   );

   // ----------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------
   always @*
   begin
      readVal = 32'h0;
      hit = 1'b1;
      if (selBuf)
      begin
         if (divisorLatchAccess)
            readVal[7:0] = divisor[7:0];
         else
            readVal[7:0] = rxBuf;
      end
      else if (selDivHi && divisorLatchAccess)
         readVal[7:0] = divisor[15:8];
      else if (selLcr)
         readVal[7:0] = lineFmt;
      else if (selMcr)
      begin
         readVal[`ULC_MCR_DTR] = terminalReadyCtl & ~loopbackSelect;
         readVal[`ULC_MCR_RTS] = requestSendCtl & ~loopbackSelect;
         readVal[`ULC_MCR_LOOP] = loopbackSelect;
      end
      else if (selStat)
      begin
         readVal[`ULC_STAT_RDY] = rxReady;
         readVal[`ULC_STAT_PERR] = parityErr;
         readVal[`ULC_STAT_FERR] = framingErr;
         readVal[`ULC_STAT_TXIDLE] = ~txBusy & ~txStart;
      end
      else
         hit = 1'b0;
   end

   // ----------------------------------------------------------------
   // apb answer, one wait-free access phase
   // ----------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         prdata <= pwrite ? 32'h0 : readVal;
         pready <= 1'b1;
         pslverr <= ~hit;
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // control registers and transmit kick
   // ----------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lineFmt <= `ULC_LCR_RESET;
         terminalReadyCtl <= `ULC_MCR_RESET;
         requestSendCtl <= `ULC_MCR_RESET;
         loopbackSelect <= `ULC_MCR_RESET;
         divisor <= `ULC_DIV_RESET;
         txStart <= 1'b0;
         txData <= 8'h00;
      end
      else
      begin
         txStart <= 1'b0;
         if (wrDone && selLcr)
            lineFmt <= pwdata[7:0];
         if (wrDone && selMcr)
         begin
            // reserved bits are not stored and read as zero
            terminalReadyCtl <= pwdata[`ULC_MCR_DTR];
            requestSendCtl <= pwdata[`ULC_MCR_RTS];
            loopbackSelect <= pwdata[`ULC_MCR_LOOP];
         end
         if (wrDone && selBuf && divisorLatchAccess)
            divisor[7:0] <= pwdata[7:0];
         if (wrDone && selDivHi && divisorLatchAccess)
            divisor[15:8] <= pwdata[7:0];
         // no holding fifo: a write while busy is dropped
         if (wrDone && selBuf && !divisorLatchAccess && !txBusy && !txStart)
         begin
            txData <= pwdata[7:0];
            txStart <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // oversampling tick, sixteen per bit
   // ----------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         divCnt <= 16'h0000;
         tick <= 1'b0;
      end
      else if (divCnt == 16'h0000)
      begin
         // a zero divisor runs at full rate rather than stalling
         divCnt <= (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
         tick <= 1'b1;
      end
      else
      begin
         divCnt <= divCnt - 16'h0001;
         tick <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // pins
   // ----------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         serialOut <= 1'b1;
         terminalReadyN <= 1'b1;
         requestSendN <= 1'b1;
      end
      else
      begin
         serialOut <= loopbackSelect ? 1'b1 : internalTx;
         terminalReadyN <= ~(terminalReadyCtl & ~loopbackSelect);
         requestSendN <= ~(requestSendCtl & ~loopbackSelect);
      end
   end

   // ----------------------------------------------------------------
   // receiver
   // ----------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rxState <= RX_IDLE;
         rxCnt <= 4'h0;
         rxBit <= 3'h0;
         rxShift <= 8'h00;
         rxPar <= 1'b0;
         rxBuf <= 8'h00;
         rxReady <= 1'b0;
         parityErr <= 1'b0;
         framingErr <= 1'b0;
      end
      else
      begin
         // reads clear first; a character landing now wins below
         if (rdDone && selBuf && !divisorLatchAccess)
            rxReady <= 1'b0;
         if (rdDone && selStat)
         begin
            parityErr <= 1'b0;
            framingErr <= 1'b0;
         end
         case (rxState)
            RX_IDLE:
            begin
               rxCnt <= 4'h0;
               if (!rxLine)
                  rxState <= RX_START;
            end
            RX_START:
            begin
               if (tick)
               begin
                  rxCnt <= rxCnt + 4'h1;
                  if (rxCnt == `ULC_TICK_MID)
                  begin
                     rxCnt <= 4'h0;
                     rxBit <= 3'h0;
                     rxShift <= 8'h00;
                     // a glitch shorter than half a bit is rejected
                     rxState <= rxLine ? RX_IDLE : RX_DATA;
                  end
               end
            end
            RX_DATA:
            begin
               if (tick)
               begin
                  rxCnt <= rxCnt + 4'h1;
                  if (rxCnt == `ULC_TICK_LAST)
                  begin
                     rxShift[rxBit] <= rxLine;
                     rxBit <= rxBit + 3'h1;
                     if (rxBit == lastBit)
                        rxState <= parityEnable ? RX_PAR : RX_STOP;
                  end
               end
            end
            RX_PAR:
            begin
               if (tick)
               begin
                  rxCnt <= rxCnt + 4'h1;
                  if (rxCnt == `ULC_TICK_LAST)
                  begin
                     rxPar <= rxLine;
                     rxState <= RX_STOP;
                  end
               end
            end
            RX_STOP:
            begin
               if (tick)
               begin
                  rxCnt <= rxCnt + 4'h1;
                  if (rxCnt == `ULC_TICK_LAST)
                  begin
                     rxBuf <= rxShift;
                     rxReady <= 1'b1;
                     if (parityEnable && rxPar != parityOf(rxShift,
                         wordLengthSel, parityTypeSel))
                        parityErr <= 1'b1;
                     if (!rxLine)
                        framingErr <= 1'b1;
                     rxState <= RX_IDLE;
                  end
               end
            end
            default:
               rxState <= RX_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// File: rtl/ulc_map.vh
/*
 * Register map, fields, resets and timing counts.
 * Assumes inclusion by bare name.
 */
`ifndef ULC_MAP_VH
`define ULC_MAP_VH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define ULC_ADDR_BUF 32'h40008000
`define ULC_ADDR_DIVHI 32'h40008004
`define ULC_ADDR_LCR 32'h4000800c
`define ULC_ADDR_MCR 32'h40008010
`define ULC_ADDR_STAT 32'h40008014

// ----------------------------------------------------------------------
// serial_line_format fields
// ----------------------------------------------------------------------
`define ULC_LCR_LEN_LSB 0
`define ULC_LCR_STOP2 2
`define ULC_LCR_PAR 3
`define ULC_LCR_PTY_LSB 4
`define ULC_LCR_BRK 6
`define ULC_LCR_DIV 7
`define ULC_LCR_RESET 8'h00

// ----------------------------------------------------------------------
// modem_output_control fields
// ----------------------------------------------------------------------
`define ULC_MCR_DTR 0
`define ULC_MCR_RTS 1
`define ULC_MCR_LOOP 4
`define ULC_MCR_RESET 1'b0

// ----------------------------------------------------------------------
// line status fields and divisor
// ----------------------------------------------------------------------
`define ULC_STAT_RDY 0
`define ULC_STAT_PERR 2
`define ULC_STAT_FERR 3
`define ULC_STAT_TXIDLE 5
`define ULC_DIV_RESET 16'h0001

// ----------------------------------------------------------------------
// timing, in oversampling ticks
// ----------------------------------------------------------------------
`define ULC_TICK_LAST 4'hf
`define ULC_TICK_MID 4'h7
`define ULC_STOP_ONE 6'h10
`define ULC_STOP_ONEHALF 6'h18
`define ULC_STOP_TWO 6'h20

`endif

// File: rtl/ulc_serial_tx.v
/*
 * Character serialiser; format latched per character.
 * Assumes a one-cycle tick at sixteen times the bit rate.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ulc_map.vh"

module ulc_serial_tx
(
   // clock and reset
   input wire sys_clk,
   input wire rst_n,
   // control
   input wire tick,
   input wire start,
   input wire [7:0] data,
   input wire [7:0] format,
   // status and line
   output reg busy,
   output reg txLine
);

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_SHIFT = 3'b010;
   localparam [2:0] ST_STOP = 3'b100;

   reg [2:0] state;
   reg [8:0] shiftReg;
   reg [3:0] bitsLeft;
   reg [3:0] subCnt;
   reg [5:0] stopLeft;
   reg [5:0] stopLen;

   wire [1:0] wlen = format[`ULC_LCR_LEN_LSB +: 2];
   wire parEn = format[`ULC_LCR_PAR];

   // ----------------------------------------------------------------
   // parity and frame building
   // ----------------------------------------------------------------
   function parityOf;
      input [7:0] d;
      input [1:0] wl;
      input [1:0] sel;
      reg [7:0] m;
      begin
         m = d & (8'hff >> (2'd3 - wl));
         case (sel)
            2'h0: parityOf = ~^m;
            2'h1: parityOf = ^m;
            2'h2: parityOf = 1'b1;
            default: parityOf = 1'b0;
         endcase
      end
   endfunction

   function [8:0] buildFrame;
      input [7:0] d;
      input [7:0] f;
      reg [8:0] r;
      reg p;
      begin
         r = {1'b0, d & (8'hff >> (2'd3 - f[1:0]))};
         p = parityOf(d, f[1:0], f[`ULC_LCR_PTY_LSB +: 2]);
         if (f[`ULC_LCR_PAR])
            r[{1'b0, f[1:0]} + 4'd5] = p;
         buildFrame = r;
      end
   endfunction

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         shiftReg <= 9'h000;
         bitsLeft <= 4'h0;
         subCnt <= 4'h0;
         stopLeft <= 6'h00;
         stopLen <= 6'h00;
         busy <= 1'b0;
         txLine <= 1'b1;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (start)
               begin
                  // format held per frame so later writes cannot tear it
                  shiftReg <= buildFrame(data, format);
                  bitsLeft <= {2'b00, wlen} + 4'd5 + {3'b000, parEn};
                  if (!format[`ULC_LCR_STOP2])
                     stopLen <= `ULC_STOP_ONE;
                  else if (wlen == 2'b00)
                     stopLen <= `ULC_STOP_ONEHALF;
                  else
                     stopLen <= `ULC_STOP_TWO;
                  subCnt <= 4'h0;
                  txLine <= 1'b0;
                  busy <= 1'b1;
                  state <= ST_SHIFT;
               end
            end
            ST_SHIFT:
            begin
               if (tick)
               begin
                  subCnt <= subCnt + 4'h1;
                  if (subCnt == `ULC_TICK_LAST)
                  begin
                     if (bitsLeft != 4'h0)
                     begin
                        txLine <= shiftReg[0];
                        shiftReg <= {1'b0, shiftReg[8:1]};
                        bitsLeft <= bitsLeft - 4'h1;
                     end
                     else
                     begin
                        txLine <= 1'b1;
                        stopLeft <= stopLen;
                        state <= ST_STOP;
                     end
                  end
               end
            end
            ST_STOP:
            begin
               if (tick)
               begin
                  stopLeft <= stopLeft - 6'h01;
                  if (stopLeft == 6'h01)
                  begin
                     busy <= 1'b0;
                     state <= ST_IDLE;
                  end
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// File: dv/ulc_line_ctrl_asserts.sv
/*
 * Port checks of the line control block.
 * Assumes ulc_map.vh; bound to ulc_line_ctrl.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ulc_map.vh"

module ulc_line_ctrl_asserts
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins
   input wire logic serialIn,
   input wire logic serialOut,
   input wire logic terminalReadyN,
   input wire logic requestSendN
);
   logic [7:0] lcrQ;
   logic [2:0] mcrQ;
   wire logic wr = psel && penable && pready && pwrite;
   wire logic wrLcr = wr && paddr == `ULC_ADDR_LCR;
   wire logic wrMcr = wr && paddr == `ULC_ADDR_MCR;
   wire logic setup = psel && !penable;

   // ------------------------------------------------------------
   // shadow of software writes
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         lcrQ <= 8'h00;
         mcrQ <= 3'h0;
      end
      else
      begin
         if (wrLcr)
            lcrQ <= pwdata[7:0];
         if (wrMcr)
            mcrQ <= {pwdata[4], pwdata[1:0]};
      end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // pins lag a write by two cycles
   sequence quiet3;
      (!wrLcr && !wrMcr) [*3];
   endsequence
   sequence startLow;
      !serialOut [*8];
   endsequence

   dtr_pin_a: assert property (
      quiet3 |-> terminalReadyN == !(mcrQ[0] && !mcrQ[2]))
      else $error("ready pin wrong");
   rts_pin_a: assert property (
      quiet3 |-> requestSendN == !(mcrQ[1] && !mcrQ[2]))
      else $error("send pin wrong");
   loop_mark_a: assert property (
      quiet3 ##0 (mcrQ[2] && !lcrQ[6]) |-> serialOut)
      else $error("no mark in loopback");
   break_low_a: assert property (
      quiet3 ##0 (lcrQ[6] && !mcrQ[2]) |-> !serialOut)
      else $error("no break low");
   start_bit_a: assert property (
      $fell(serialOut) && !lcrQ[6] |-> startLow)
      else $error("start bit short");
   fmt_read_a: assert property (
      setup && !pwrite && paddr == `ULC_ADDR_LCR
      |=> prdata == {24'h0, lcrQ})
      else $error("format readback");
   loop_read_a: assert property (
      setup && !pwrite && paddr == `ULC_ADDR_MCR && mcrQ[2]
      |=> pready && prdata[1:0] == 2'b00)
      else $error("loop modem bits");
   latch_shut_a: assert property (
      setup && paddr == `ULC_ADDR_DIVHI && !lcrQ[7] |=> pready && pslverr)
      else $error("latch not shut");
   latch_open_a: assert property (
      setup && paddr == `ULC_ADDR_DIVHI && lcrQ[7] |=> pready && !pslverr)
      else $error("latch not open");
endmodule

bind ulc_line_ctrl ulc_line_ctrl_asserts chk_u
(
   .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .serialIn(serialIn),
   .serialOut(serialOut), .terminalReadyN(terminalReadyN),
   .requestSendN(requestSendN)
);
`default_nettype wire

// File: dv/ulc_remote_uart.sv
/*
 * Remote serial partner.
 * Assumes BIT clock cycles a bit; idle line high.
 */
`timescale 1ns/1ns
`default_nettype none

module ulc_remote_uart
#(
   parameter int BIT = 16
)
(
   // clock
   input wire logic sys_clk,
   // serial lines
   input wire logic fromDut,
   output var logic toDut
);
   initial toDut = 1'b1;

   function automatic logic parBit(input logic [7:0] f, input logic [7:0] d);
      logic [7:0] m;
      m = d & (8'hff >> (2'd3 - f[1:0]));
      case (f[5:4])
         2'd0: parBit = ~^m;
         2'd1: parBit = ^m;
         2'd2: parBit = 1'b1;
         default: parBit = 1'b0;
      endcase
   endfunction

   task automatic bitOut(input logic v);
      toDut <= v;
      repeat (BIT) @(posedge sys_clk);
   endtask

   // ------------------------------------------------------------
   // frame send and capture
   // ------------------------------------------------------------
   task automatic send(input logic [7:0] f, input logic [7:0] d,
      input logic badPar);
      bitOut(1'b0);
      for (int i = 0; i < 5 + f[1:0]; i++)
         bitOut(d[i]);
      if (f[3])
         bitOut(parBit(f, d) ^ badPar);
      bitOut(1'b1);
      if (f[2])
         bitOut(1'b1);
   endtask

   // samples mid-bit; call before the frame starts
   task automatic grab(input logic [7:0] f, output logic [7:0] d,
      output logic p);
      d = 8'h00;
      p = 1'b0;
      @(negedge fromDut);
      repeat (BIT / 2) @(posedge sys_clk);
      for (int i = 0; i < 5 + f[1:0]; i++)
      begin
         repeat (BIT) @(posedge sys_clk);
         d[i] = fromDut;
      end
      if (f[3])
      begin
         repeat (BIT) @(posedge sys_clk);
         p = fromDut;
      end
   endtask
endmodule
`default_nettype wire

// File: dv/tb_uart_line_and_modem_control.sv
/*
 * Bench for the line control block.
 * Assumes divisor one: a bit lasts 16 cycles.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ulc_map.vh"

module tb_uart_line_and_modem_control;
   logic sys_clk, rst_n, psel, penable, pwrite, gp, err, ok;
   logic [31:0] paddr, pwdata, rd;
   logic [7:0] gd;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, serialIn, serialOut;
   wire logic terminalReadyN, requestSendN;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   int k, t0, t1;

   typedef struct {logic [7:0] f, d, ed; logic ep; int frm;} ulc_row_t;
   // format, data, data seen, parity seen, frame cycles
   ulc_row_t rows [8] = '{
      '{8'h03, 8'ha5, 8'ha5, 1'b0, 160}, '{8'h00, 8'hff, 8'h1f, 1'b0, 112},
      '{8'h05, 8'h3c, 8'h3c, 1'b0, 144}, '{8'h0e, 8'h35, 8'h35, 1'b1, 176},
      '{8'h1b, 8'hc1, 8'hc1, 1'b1, 176}, '{8'h2b, 8'h00, 8'h00, 1'b1, 176},
      '{8'h3b, 8'hff, 8'hff, 1'b0, 176}, '{8'h04, 8'h2a, 8'h0a, 1'b0, 120}};

   ulc_line_ctrl dut_u
   (
      .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .serialIn(serialIn),
      .serialOut(serialOut), .terminalReadyN(terminalReadyN),
      .requestSendN(requestSendN)
   );
   ulc_remote_uart #(.BIT(16)) rem_u
   (
      .sys_clk(sys_clk), .fromDut(serialOut), .toDut(serialIn)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) cyc <= cyc + 1;

   // ------------------------------------------------------------
   // bus and compare tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [31:0] a,
      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
         @(posedge sys_clk);
      while (pready !== 1'b1 && ++n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask

   task automatic rdc(input string what, input logic [31:0] a,
      input logic [31:0] mask, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd & mask);
   endtask

   task automatic results;
      if (n_mismatch == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      #(20000 * 100);
      n_mismatch++;
      results;
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rdc("format", `ULC_ADDR_LCR, 32'hff, 32'h0);
      rdc("modem", `ULC_ADDR_MCR, 32'h13, 32'h0);
      chk("pins", 32'h7, {serialOut, terminalReadyN, requestSendN});
      foreach (rows[i])
      begin
         wr(`ULC_ADDR_LCR, rows[i].f);
         fork
            rem_u.grab(rows[i].f, gd, gp);
            begin
               wr(`ULC_ADDR_BUF, rows[i].d);
               t0 = cyc;
               k = 0;
               do
                  apb(1'b0, `ULC_ADDR_STAT, 32'h0);
               while (rd[5] !== 1'b1 && ++k < 100);
               t1 = cyc;
            end
         join
         ok = t1 - t0 >= rows[i].frm - 2 && t1 - t0 <= rows[i].frm + 6;
         chk("tx data", {24'h0, rows[i].ed}, {24'h0, gd});
         chk("tx parity", {31'h0, rows[i].ep}, {31'h0, gp});
         chk("tx frame", 32'h1, {31'h0, ok});
         rem_u.send(rows[i].f, rows[i].d, 1'b0);
         rdc("rx status", `ULC_ADDR_STAT, 32'h0d, 32'h01);
         rdc("rx data", `ULC_ADDR_BUF, 32'hff, {24'h0, rows[i].ed});
      end
      wr(`ULC_ADDR_LCR, 8'h1b);
      rem_u.send(8'h1b, 8'h5a, 1'b1);
      rdc("parity error", `ULC_ADDR_STAT, 32'h05, 32'h05);
      rdc("rx data", `ULC_ADDR_BUF, 32'hff, 32'h5a);
      wr(`ULC_ADDR_LCR, 8'h03);
      fork
         rem_u.grab(8'h03, gd, gp);
         begin
            wr(`ULC_ADDR_BUF, 8'h96);
            repeat (40) @(posedge sys_clk);
            wr(`ULC_ADDR_LCR, 8'h00);
         end
      join
      chk("mid frame write", 32'h96, {24'h0, gd});
      repeat (200) @(posedge sys_clk);
      apb(1'b0, `ULC_ADDR_DIVHI, 32'h0);
      chk("latch shut", 32'h1, {31'h0, err});
      apb(1'b0, 32'h40008018, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      wr(`ULC_ADDR_LCR, 8'h80);
      wr(`ULC_ADDR_DIVHI, 8'h12);
      rdc("divisor high", `ULC_ADDR_DIVHI, 32'hff, 32'h12);
      rdc("divisor low", `ULC_ADDR_BUF, 32'hff, 32'h01);
      wr(`ULC_ADDR_DIVHI, 8'h00);
      // the tick counter still drains the long test divisor
      repeat (4700) @(posedge sys_clk);
      wr(`ULC_ADDR_LCR, 8'h03);
      for (int m = 0; m < 4; m++)
      begin
         wr(`ULC_ADDR_MCR, m[7:0]);
         repeat (2) @(posedge sys_clk);
         chk("ready pin", {31'h0, !m[0]}, {31'h0, terminalReadyN});
         chk("send pin", {31'h0, !m[1]}, {31'h0, requestSendN});
         rdc("modem bits", `ULC_ADDR_MCR, 32'h03, 32'(m));
      end
      wr(`ULC_ADDR_MCR, 8'h13);
      k = 0;
      // the far side talks meanwhile; loopback must ignore it
      fork
         rem_u.send(8'h03, 8'hc3, 1'b0);
         begin
            wr(`ULC_ADDR_BUF, 8'h5a);
            repeat (200)
            begin
               @(posedge sys_clk);
               if ({serialOut, terminalReadyN, requestSendN} !== 3'b111)
                  k++;
            end
         end
      join
      chk("loop pins", 32'h0, 32'(k));
      rdc("loop modem", `ULC_ADDR_MCR, 32'h13, 32'h10);
      rdc("loop status", `ULC_ADDR_STAT, 32'h0d, 32'h01);
      rdc("loop data", `ULC_ADDR_BUF, 32'hff, 32'h5a);
      wr(`ULC_ADDR_MCR, 8'h00);
      wr(`ULC_ADDR_LCR, 8'h43);
      repeat (3) @(posedge sys_clk);
      chk("break pin", 32'h0, {31'h0, serialOut});
      wr(`ULC_ADDR_LCR, 8'h03);
      repeat (3) @(posedge sys_clk);
      chk("mark pin", 32'h1, {31'h0, serialOut});
      results;
   end
endmodule
`default_nettype wire
